// >>> src/gsu_status_upload.sv
// Purpose: Status byte, enable masks, service request and waveform upload.
// Assumes: Status inputs and decoded commands come from logic on clk_sys.
// Notes:   Query answers are binary bytes; formatting to text is done outside.
//
// Notes on behaviour
// - Bit 7 reports calculating.
// - Bits 3..0: armed, running, overload, arbitrary mode.
// - Bit 5 is OR of enabled events.
// - Bit 4 set while output queue holds data.
// - Poll returns status with request flag in bit 6.
// - Poll clears the request flag; other stored status bits unchanged.
// - Query byte carries summary in bit 6.
// - Request enable ignores written bit 6.
// - Event enable writable, readable; events readable.
// - Select command enters arbitrary mode; upload accepted in either mode.
// - Rate commands capped 50 MHz internal, 25 external; reset rate is 50 MHz.
// - Upload data goes to output waveform memory.
// - Point count 2048 to 262144, two bytes each.
// - Pair: first high nibble low bits, second high.
// - Samples are two's complement codes.
// - Block: hash, digit count, size, then data.
// - Accept blocks until declared total byte count.
// - Discard messages arriving during an upload.
// - Line feed inside block is plain data.
`timescale 1ns/1ps
`include "gsu_params.svh"

module gsu_status_upload #(
  parameter int ADDR_W = 18
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      calculating,
  input  wire logic                      triggerArmed,
  input  wire logic                      outputActive,
  input  wire logic                      outputOverloadFlag,
  input  wire logic                      extClockSel,
  input  wire logic [7:0]                eventSet,
  input  wire logic                      queueHasData,
  input  wire logic                      cmdValid,
  input  wire gsu_pkg::gsu_cmd_type      cmdCode,
  input  wire logic [`GSU_RATE_W-1:0]    cmdArg,
  input  wire logic [7:0]                rxByte,
  input  wire logic                      rxValid,
  input  wire logic                      pollReq,
  input  wire logic                      respReady,
  output logic                           busy,
  output logic [7:0]                     pollByte,
  output logic                           pollValid,
  output logic [7:0]                     respByte,
  output logic                           respValid,
  output logic                           srqOut,
  output logic                           arbitraryModeFlag,
  output logic [`GSU_RATE_W-1:0]         sampleRate,
  output logic                           rateRejected,
  output logic                           uploadRejected,
  output logic                           uploadDone,
  output logic                           memWrite,
  output logic [ADDR_W-1:0]              memAddr,
  output logic [11:0]                    memData
);
  import gsu_pkg::*;

  // ****************************************
  // Status byte and summary
  // ****************************************
  logic [7:0]               serviceEnable;
  logic [7:0]               eventEnable;
  logic [7:0]               eventFlags;
  logic [7:0]               statusBits;
  logic                     summary;
  logic                     summaryLast;
  logic                     cmdTake;

  // While an upload runs, decoded messages are dropped on the floor.
  assign cmdTake = cmdValid && !busy;

  always_comb begin
    statusBits = 8'h00;
    statusBits[`GSU_STB_CALC]      = calculating;
    statusBits[`GSU_STB_EVENT]     = |(eventFlags & eventEnable);
    statusBits[`GSU_STB_MSG_AVAIL] = queueHasData || respValid;
    statusBits[`GSU_STB_ARMED]     = triggerArmed;
    statusBits[`GSU_STB_RUNNING]   = outputActive;
    statusBits[`GSU_STB_OVERLOAD]  = outputOverloadFlag;
    statusBits[`GSU_STB_ARB]       = arbitraryModeFlag;
  end

  // Bit 6 of statusBits is always zero, so it never feeds the summary.
  assign summary = |(statusBits & serviceEnable);

  // ****************************************
  // Enable registers, event flags, mode
  // ****************************************
  logic [7:0]               next_serviceEnable;
  logic [7:0]               next_eventEnable;
  logic [7:0]               next_eventFlags;
  logic                     next_arbitraryModeFlag;
  logic [`GSU_RATE_W-1:0]   next_sampleRate;
  logic                     next_rateRejected;
  logic [`GSU_RATE_W-1:0]   rateLimit;

  assign rateLimit = extClockSel ? `GSU_RATE_EXT_MAX_HZ : `GSU_RATE_INT_MAX_HZ;

  always_comb begin
    next_serviceEnable     = serviceEnable;
    next_eventEnable       = eventEnable;
    next_eventFlags        = eventFlags;
    next_arbitraryModeFlag = arbitraryModeFlag;
    next_sampleRate        = sampleRate;
    next_rateRejected      = 1'b0;
    if (cmdTake) begin
      case (cmdCode)
        CMD_SRE_SET:   next_serviceEnable = cmdArg[7:0] & `GSU_SRE_WRITE_MASK;
        CMD_ESE_SET:   next_eventEnable   = cmdArg[7:0];
        CMD_ESR_QUERY: next_eventFlags    = 8'h00;
        CMD_CLEAR:     next_eventFlags    = 8'h00;
        CMD_ARB_SEL:   next_arbitraryModeFlag = 1'b1;
        CMD_STD_SEL:   next_arbitraryModeFlag = 1'b0;
        CMD_SET_RATE: begin
          if (cmdArg != '0 && cmdArg <= rateLimit) begin
            next_sampleRate = cmdArg;
          end else begin
            next_rateRejected = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // New events are ORed in after any clear so a same-cycle event survives.
    next_eventFlags = next_eventFlags | eventSet;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      serviceEnable     <= `GSU_SRE_RESET;
      eventEnable       <= `GSU_ESE_RESET;
      eventFlags        <= `GSU_ESR_RESET;
      arbitraryModeFlag <= 1'b0;
      sampleRate        <= `GSU_RATE_INT_MAX_HZ;
      rateRejected      <= 1'b0;
    end else begin
      serviceEnable     <= next_serviceEnable;
      eventEnable       <= next_eventEnable;
      eventFlags        <= next_eventFlags;
      arbitraryModeFlag <= next_arbitraryModeFlag;
      sampleRate        <= next_sampleRate;
      rateRejected      <= next_rateRejected;
    end
  end

  // ****************************************
  // Service request, serial poll, queries
  // ****************************************
  logic                     next_srqOut;
  logic                     next_summaryLast;
  logic [7:0]               next_pollByte;
  logic                     next_pollValid;
  logic [7:0]               next_respByte;
  logic                     next_respValid;

  always_comb begin
    next_summaryLast = summary;
    next_pollByte    = pollByte;
    next_pollValid   = 1'b0;
    next_respByte    = respByte;
    next_respValid   = respValid && !respReady;
    // The request drops once polled or once the summary falls; a new rise wins.
    next_srqOut = (summary && !summaryLast) || (srqOut && summary && !pollReq);
    if (pollReq) begin
      next_pollByte = statusBits;
      next_pollByte[`GSU_STB_SUMMARY] = srqOut;
      next_pollValid = 1'b1;
    end
    if (cmdTake) begin
      case (cmdCode)
        CMD_STB_QUERY: begin
          next_respByte = statusBits;
          next_respByte[`GSU_STB_SUMMARY] = summary;
          next_respValid = 1'b1;
        end
        CMD_SRE_QUERY: begin
          next_respByte  = serviceEnable;
          next_respValid = 1'b1;
        end
        CMD_ESE_QUERY: begin
          next_respByte  = eventEnable;
          next_respValid = 1'b1;
        end
        CMD_ESR_QUERY: begin
          next_respByte  = eventFlags;
          next_respValid = 1'b1;
        end
        // A summary rise in the clearing cycle still raises the request.
        CMD_CLEAR: next_srqOut = summary && !summaryLast;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      srqOut      <= 1'b0;
      summaryLast <= 1'b0;
      pollByte    <= 8'h00;
      pollValid   <= 1'b0;
      respByte    <= 8'h00;
      respValid   <= 1'b0;
    end else begin
      srqOut      <= next_srqOut;
      summaryLast <= next_summaryLast;
      pollByte    <= next_pollByte;
      pollValid   <= next_pollValid;
      respByte    <= next_respByte;
      respValid   <= next_respValid;
    end
  end

  // ****************************************
  // Upload sequencing
  // ****************************************
  gsu_upload_type           upState;
  gsu_upload_type           next_upState;
  logic [`GSU_COUNT_W-1:0]  totalLeft;
  logic [`GSU_COUNT_W-1:0]  next_totalLeft;
  logic [`GSU_COUNT_W-1:0]  blockLeft;
  logic [`GSU_COUNT_W-1:0]  next_blockLeft;
  logic                     next_uploadRejected;
  logic                     next_uploadDone;
  logic                     upRestart;
  logic                     headerDone;
  logic [`GSU_COUNT_W-1:0]  blockSize;
  logic                     dataByte;
  logic [`GSU_COUNT_W-1:0]  reqBytes;
  logic                     countOk;

  assign reqBytes  = cmdArg[`GSU_COUNT_W-1:0];
  assign countOk   = (cmdArg[`GSU_RATE_W-1:`GSU_COUNT_W] == '0) && !reqBytes[0]
                   && (reqBytes >= {`GSU_MIN_POINTS, 1'b0})
                   && (reqBytes <= {`GSU_MAX_POINTS, 1'b0});
  assign upRestart = cmdTake && cmdCode == CMD_UPLOAD && countOk;
  // Any byte value, line feed included, is data inside a block.
  assign dataByte  = rxValid && upState == UP_DATA;
  assign busy      = upState != UP_IDLE;

  always_comb begin
    next_upState        = upState;
    next_totalLeft      = totalLeft;
    next_blockLeft      = blockLeft;
    next_uploadRejected = 1'b0;
    next_uploadDone     = 1'b0;
    case (upState)
      UP_IDLE: begin
        if (cmdTake && cmdCode == CMD_UPLOAD) begin
          if (countOk) begin
            next_totalLeft = reqBytes;
            next_upState   = UP_HEADER;
          end else begin
            next_uploadRejected = 1'b1;
          end
        end
      end
      UP_HEADER: begin
        // An empty block carries nothing; wait for the next header.
        if (headerDone && blockSize != '0) begin
          next_blockLeft = blockSize;
          next_upState   = UP_DATA;
        end
      end
      UP_DATA: begin
        if (rxValid) begin
          next_blockLeft = blockLeft - 1'b1;
          next_totalLeft = totalLeft - 1'b1;
          if (totalLeft == `GSU_COUNT_W'(1)) begin
            next_uploadDone = 1'b1;
            next_upState    = UP_IDLE;
          end else if (blockLeft == `GSU_COUNT_W'(1)) begin
            next_upState = UP_HEADER;
          end
        end
      end
      default: next_upState = UP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      upState        <= UP_IDLE;
      totalLeft      <= '0;
      blockLeft      <= '0;
      uploadRejected <= 1'b0;
      uploadDone     <= 1'b0;
    end else begin
      upState        <= next_upState;
      totalLeft      <= next_totalLeft;
      blockLeft      <= next_blockLeft;
      uploadRejected <= next_uploadRejected;
      uploadDone     <= next_uploadDone;
    end
  end

  // ****************************************
  // Header parser and sample packer
  // ****************************************
  gsu_block_header u_header (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .restart    (upRestart),
    .byteIn     (rxByte),
    .byteValid  (rxValid && upState == UP_HEADER),
    .headerDone (headerDone),
    .blockSize  (blockSize)
  );

  gsu_sample_packer #(
    .ADDR_W (ADDR_W)
  ) u_packer (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .restart   (upRestart),
    .byteIn    (rxByte),
    .byteValid (dataByte),
    .memWrite  (memWrite),
    .memAddr   (memAddr),
    .memData   (memData)
  );

endmodule : gsu_status_upload

// >>> src/gsu_params.svh
// Purpose: Constants for the status reporting and waveform upload block.
// Assumes: Included by every design module of the block.
// Notes:   Offsets, field positions, reset values and limits live here only.
`ifndef GSU_PARAMS_SVH
`define GSU_PARAMS_SVH

// ****************************************
// Status byte field positions
// ****************************************
`define GSU_STB_CALC      7
`define GSU_STB_SUMMARY   6
`define GSU_STB_EVENT     5
`define GSU_STB_MSG_AVAIL 4
`define GSU_STB_ARMED     3
`define GSU_STB_RUNNING   2
`define GSU_STB_OVERLOAD  1
`define GSU_STB_ARB       0
`define GSU_SRE_WRITE_MASK 8'hbf

// ****************************************
// Reset values
// ****************************************
`define GSU_SRE_RESET     8'h00
`define GSU_ESE_RESET     8'h00
`define GSU_ESR_RESET     8'h00

// ****************************************
// Upload limits and block syntax
// ****************************************
`define GSU_COUNT_W       20
`define GSU_MIN_POINTS    20'h00800
`define GSU_MAX_POINTS    20'h40000
`define GSU_ASCII_HASH    8'h23
`define GSU_ASCII_ZERO    8'h30
`define GSU_ASCII_NINE    8'h39

// ****************************************
// Sample clock limits in Hz
// ****************************************
`define GSU_RATE_W        26
`define GSU_RATE_INT_MAX_HZ 26'h2faf080
`define GSU_RATE_EXT_MAX_HZ 26'h17d7840

`endif

// >>> src/gsu_pkg.sv
// Purpose: Types shared by the status and upload block.
// Assumes: Constants come from gsu_params.svh.
// Notes:   Command codes are produced by the message decoder in front.
package gsu_pkg;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_SRE_SET   = 4'h1,
    CMD_SRE_QUERY = 4'h2,
    CMD_ESE_SET   = 4'h3,
    CMD_ESE_QUERY = 4'h4,
    CMD_ESR_QUERY = 4'h5,
    CMD_STB_QUERY = 4'h6,
    CMD_CLEAR     = 4'h7,
    CMD_ARB_SEL   = 4'h8,
    CMD_STD_SEL   = 4'h9,
    CMD_SET_RATE  = 4'ha,
    CMD_UPLOAD    = 4'hb
  } gsu_cmd_type;

  typedef enum logic [1:0] {
    UP_IDLE   = 2'h0,
    UP_HEADER = 2'h1,
    UP_DATA   = 2'h2
  } gsu_upload_type;

  typedef enum logic [1:0] {
    HDR_HASH  = 2'h0,
    HDR_NDIG  = 2'h1,
    HDR_SIZE  = 2'h2
  } gsu_header_type;

endpackage : gsu_pkg

// >>> src/gsu_block_header.sv
// Purpose: Parses the definite-length block header of an upload.
// Assumes: Bytes arrive one per valid cycle on the system clock.
// Notes:   Bytes before the number sign are dropped silently.
`timescale 1ns/1ps
`include "gsu_params.svh"

module gsu_block_header (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      restart,
  input  wire logic [7:0]                byteIn,
  input  wire logic                      byteValid,
  output logic                           headerDone,
  output logic [`GSU_COUNT_W-1:0]        blockSize
);
  import gsu_pkg::*;

  gsu_header_type              state;
  gsu_header_type              next_state;
  logic [3:0]                  digitsLeft;
  logic [3:0]                  next_digitsLeft;
  logic [`GSU_COUNT_W-1:0]     next_blockSize;
  logic                        next_headerDone;
  logic                        isDigit;
  logic [3:0]                  digit;

  assign isDigit = (byteIn >= `GSU_ASCII_ZERO) && (byteIn <= `GSU_ASCII_NINE);
  assign digit   = byteIn[3:0];

  always_comb begin
    next_state      = state;
    next_digitsLeft = digitsLeft;
    next_blockSize  = blockSize;
    next_headerDone = 1'b0;
    if (restart) begin
      next_state = HDR_HASH;
    end else if (byteValid) begin
      case (state)
        HDR_HASH: begin
          if (byteIn == `GSU_ASCII_HASH) begin
            next_state = HDR_NDIG;
          end
        end
        HDR_NDIG: begin
          // A zero digit count would name no size field, so it is refused.
          if (isDigit && digit != 4'h0) begin
            next_digitsLeft = digit;
            next_blockSize  = '0;
            next_state      = HDR_SIZE;
          end else begin
            next_state = HDR_HASH;
          end
        end
        HDR_SIZE: begin
          if (isDigit) begin
            next_blockSize  = `GSU_COUNT_W'(blockSize * 10 + {16'h0000, digit});
            next_digitsLeft = digitsLeft - 4'h1;
            if (digitsLeft == 4'h1) begin
              next_headerDone = 1'b1;
              next_state      = HDR_HASH;
            end
          end else begin
            next_state = HDR_HASH;
          end
        end
        default: next_state = HDR_HASH;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state      <= HDR_HASH;
      digitsLeft <= 4'h0;
      blockSize  <= '0;
      headerDone <= 1'b0;
    end else begin
      state      <= next_state;
      digitsLeft <= next_digitsLeft;
      blockSize  <= next_blockSize;
      headerDone <= next_headerDone;
    end
  end

endmodule : gsu_block_header

// >>> src/gsu_sample_packer.sv
// Purpose: Joins byte pairs into 12-bit samples and writes them to memory.
// Assumes: restart pulses once before the first byte of an upload.
// Notes:   The low nibble of the first byte of a pair is unused.
`timescale 1ns/1ps
`include "gsu_params.svh"

module gsu_sample_packer #(
  parameter int ADDR_W = 18
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               restart,
  input  wire logic [7:0]         byteIn,
  input  wire logic               byteValid,
  output logic                    memWrite,
  output logic [ADDR_W-1:0]       memAddr,
  output logic [11:0]             memData
);
  import gsu_pkg::*;

  logic                 secondByte;
  logic                 next_secondByte;
  logic [3:0]           lowNibble;
  logic [3:0]           next_lowNibble;
  logic [ADDR_W-1:0]    writeAddr;
  logic [ADDR_W-1:0]    next_writeAddr;
  logic                 next_memWrite;
  logic [ADDR_W-1:0]    next_memAddr;
  logic [11:0]          next_memData;

  always_comb begin
    next_secondByte = secondByte;
    next_lowNibble  = lowNibble;
    next_writeAddr  = writeAddr;
    next_memWrite   = 1'b0;
    next_memAddr    = memAddr;
    next_memData    = memData;
    if (restart) begin
      next_secondByte = 1'b0;
      next_writeAddr  = '0;
    end else if (byteValid) begin
      if (!secondByte) begin
        next_lowNibble  = byteIn[7:4];
        next_secondByte = 1'b1;
      end else begin
        // Two's-complement code passes unchanged to the converter.
        next_memData    = {byteIn, lowNibble};
        next_memAddr    = writeAddr;
        next_memWrite   = 1'b1;
        next_writeAddr  = writeAddr + 1'b1;
        next_secondByte = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      secondByte <= 1'b0;
      lowNibble  <= 4'h0;
      writeAddr  <= '0;
      memWrite   <= 1'b0;
      memAddr    <= '0;
      memData    <= 12'h000;
    end else begin
      secondByte <= next_secondByte;
      lowNibble  <= next_lowNibble;
      writeAddr  <= next_writeAddr;
      memWrite   <= next_memWrite;
      memAddr    <= next_memAddr;
      memData    <= next_memData;
    end
  end

endmodule : gsu_sample_packer

// >>> sim/gsu_status_upload_monitor.sv
// Purpose: Port-level checks of the status and upload block.
// Assumes: One clock domain; resetn is synchronous and active low.
// Notes:   Bound to every instance of gsu_status_upload.
`timescale 1ns/1ps

module gsu_status_upload_monitor (
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 calculating,
  input wire logic                 triggerArmed,
  input wire logic                 outputOverloadFlag,
  input wire logic                 queueHasData,
  input wire logic                 cmdValid,
  input wire gsu_pkg::gsu_cmd_type cmdCode,
  input wire logic                 pollReq,
  input wire logic                 busy,
  input wire logic [7:0]           pollByte,
  input wire logic                 pollValid,
  input wire logic [7:0]           respByte,
  input wire logic                 respValid,
  input wire logic                 srqOut,
  input wire logic                 arbitraryModeFlag,
  input wire logic                 uploadDone,
  input wire logic                 memWrite
);
  import gsu_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_poll_rqs;
    pollReq |=> pollValid && pollByte[6] == $past(srqOut);
  endproperty
  a_poll_rqs: assert property (p_poll_rqs) else $error("poll not answered");
  property p_poll_bits;
    pollReq |=> pollByte[7] == $past(calculating) && pollByte[3] == $past(triggerArmed)
      && pollByte[1] == $past(outputOverloadFlag) && pollByte[0] == $past(arbitraryModeFlag);
  endproperty
  a_poll_bits: assert property (p_poll_bits) else $error("poll bits wrong");
  property p_poll_mav;
    pollReq && queueHasData |=> pollByte[4];
  endproperty
  a_poll_mav: assert property (p_poll_mav) else $error("poll lost bit 4");
  property p_poll_keep;
    pollReq && !cmdValid |=> $stable(arbitraryModeFlag);
  endproperty
  a_poll_keep: assert property (p_poll_keep) else $error("poll changed state");
  property p_query;
    cmdValid && !busy && cmdCode == CMD_STB_QUERY |=> respValid
      && respByte[7] == $past(calculating) && respByte[0] == $past(arbitraryModeFlag);
  endproperty
  a_query: assert property (p_query) else $error("status query wrong");
  property p_arb_sel;
    cmdValid && !busy && cmdCode == CMD_ARB_SEL |=> arbitraryModeFlag;
  endproperty
  a_arb_sel: assert property (p_arb_sel) else $error("mode select ignored");
  property p_discard;
    busy && cmdValid |=> $stable(arbitraryModeFlag);
  endproperty
  a_discard: assert property (p_discard) else $error("command taken while busy");
  property p_done;
    uploadDone |-> !busy ##1 !uploadDone;
  endproperty
  a_done: assert property (p_done) else $error("done pulse wrong");
  property p_mem;
    memWrite |-> busy || uploadDone;
  endproperty
  a_mem: assert property (p_mem) else $error("memory write outside upload");

  c_srq_poll: cover property (pollValid && pollByte[6]);
  c_done: cover property (uploadDone);
  c_mem: cover property (memWrite && busy);
endmodule : gsu_status_upload_monitor

bind gsu_status_upload gsu_status_upload_monitor u_gsu_status_upload_monitor (.*);

// >>> sim/gsu_host_model.sv
// Purpose: Bus controller side that streams upload blocks.
// Assumes: One byte per rxValid cycle on clk_sys.
// Notes:   A slow block leaves an idle cycle after every data byte.
`timescale 1ns/1ps

module gsu_host_model (
  input  wire logic  clk_sys,
  output logic [7:0] rxByte,
  output logic       rxValid
);
  initial begin
    rxByte = 8'h00;
    rxValid = 1'b0;
  end

  task automatic put(input logic [7:0] b);
    @(posedge clk_sys) #1;
    rxByte = b;
    rxValid = 1'b1;
  endtask : put

  // A released lane changes pattern so a stale byte can never look valid.
  task automatic idle();
    @(posedge clk_sys) #1;
    rxValid = 1'b0;
    rxByte = ~rxByte;
  endtask : idle

  task automatic block(input int first, input bit slow);
    logic [11:0] s;
    put(8'h23);
    put(8'h34);
    put(8'h32);
    put(8'h30);
    put(8'h34);
    put(8'h38);
    idle();
    for (int i = 0; i < 1024; i++) begin
      s = 12'h7ff + 12'(first + i);
      put({s[3:0], 4'ha});
      if (slow) idle();
      put(s[11:4]);
      if (slow) idle();
    end
    idle();
  endtask : block
endmodule : gsu_host_model

// >>> sim/test_gsu_status_upload.sv
// Purpose: Self-checking bench for the status and upload block.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Upload runs at the 4096-byte minimum to keep the run short.
`timescale 1ns/1ps
`include "gsu_params.svh"

module test_gsu_status_upload;
  import gsu_pkg::*;
  logic clk_sys, resetn, calculating, triggerArmed, outputActive, outputOverloadFlag;
  logic extClockSel, queueHasData, cmdValid, pollReq, respReady, rxValid;
  logic busy, pollValid, respValid, srqOut, arbitraryModeFlag, rateRejected;
  logic uploadRejected, uploadDone, memWrite;
  logic [7:0]             eventSet, rxByte, pollByte, respByte;
  logic [`GSU_RATE_W-1:0] cmdArg, sampleRate;
  logic [17:0]            memAddr;
  logic [11:0]            memData;
  gsu_cmd_type            cmdCode;
  int                     err_count, n_compared, nMem;

  gsu_status_upload u_gsu_status_upload (.clk_sys, .resetn, .calculating, .triggerArmed,
    .outputActive, .outputOverloadFlag, .extClockSel, .eventSet, .queueHasData, .cmdValid,
    .cmdCode, .cmdArg, .rxByte, .rxValid, .pollReq, .respReady, .busy, .pollByte, .pollValid,
    .respByte, .respValid, .srqOut, .arbitraryModeFlag, .sampleRate, .rateRejected,
    .uploadRejected, .uploadDone, .memWrite, .memAddr, .memData);
  gsu_host_model u_gsu_host_model (.clk_sys, .rxByte, .rxValid);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic cmd(input gsu_cmd_type c, input int a);
    @(posedge clk_sys) #1;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdArg = 26'(a);
    @(posedge clk_sys) #1;
    cmdValid = 1'b0;
  endtask : cmd

  task automatic q(input gsu_cmd_type c, input logic [7:0] exp);
    cmd(c, 0);
    chk({respValid, respByte}, {1'b1, exp});
  endtask : q

  task automatic poll(input logic [7:0] exp);
    @(posedge clk_sys) #1;
    pollReq = 1'b1;
    @(posedge clk_sys) #1;
    pollReq = 1'b0;
    chk({pollValid, pollByte}, {1'b1, exp});
  endtask : poll

  // Every sample written must follow the ramp the host model sends.
  always @(negedge clk_sys) begin
    if (memWrite === 1'b1) begin
      chk(memAddr, 18'(nMem));
      chk(memData, 12'h7ff + 12'(nMem));
      nMem++;
    end
  end

  task automatic t_status();
    q(CMD_SRE_QUERY, 8'h00);
    chk(sampleRate, 50000000);
    {calculating, triggerArmed, outputOverloadFlag, queueHasData} = 4'hf;
    poll(8'h9a);
    poll(8'h9a);
    q(CMD_STB_QUERY, 8'h9a);
    calculating = 1'b0;
    outputActive = 1'b1;
    poll(8'h1e);
  endtask : t_status

  task automatic t_events();
    cmd(CMD_ESE_SET, 8'h24);
    q(CMD_ESE_QUERY, 8'h24);
    @(posedge clk_sys) #1;
    eventSet = 8'h04;
    @(posedge clk_sys) #1;
    eventSet = 8'h00;
    q(CMD_STB_QUERY, 8'h3e);
    q(CMD_ESR_QUERY, 8'h04);
    q(CMD_STB_QUERY, 8'h1e);
    cmd(CMD_SRE_SET, 8'hff);
    q(CMD_SRE_QUERY, 8'hbf);
    q(CMD_STB_QUERY, 8'h5e);
    poll(8'h5e);
    poll(8'h1e);
    @(posedge clk_sys) #1;
    eventSet = 8'h01;
    @(posedge clk_sys) #1;
    eventSet = 8'h00;
    cmd(CMD_CLEAR, 0);
    q(CMD_ESR_QUERY, 8'h00);
    cmd(CMD_SRE_SET, 8'h00);
  endtask : t_events

  task automatic t_rate();
    extClockSel = 1'b1;
    cmd(CMD_SET_RATE, 25000001);
    chk(rateRejected, 1'b1);
    cmd(CMD_SET_RATE, 25000000);
    chk(sampleRate, 25000000);
  endtask : t_rate

  task automatic t_upload();
    cmd(CMD_ARB_SEL, 0);
    chk(arbitraryModeFlag, 1'b1);
    cmd(CMD_UPLOAD, 4094);
    chk({uploadRejected, busy}, 2'b10);
    cmd(CMD_UPLOAD, 524290);
    chk({uploadRejected, busy}, 2'b10);
    cmd(CMD_UPLOAD, 4096);
    chk(busy, 1'b1);
    cmd(CMD_STD_SEL, 0);
    u_gsu_host_model.block(0, 1'b1);
    chk(busy, 1'b1);
    u_gsu_host_model.block(1024, 1'b0);
    chk({uploadDone, busy}, 2'b10);
    // The last sample is counted at the following falling edge.
    @(posedge clk_sys) #1;
    chk(nMem, 2048);
    chk(arbitraryModeFlag, 1'b1);
  endtask : t_upload

  initial begin
    {resetn, calculating, triggerArmed, outputActive, outputOverloadFlag} = '0;
    {extClockSel, queueHasData, cmdValid, pollReq, eventSet, cmdArg} = '0;
    respReady = 1'b1;
    cmdCode = CMD_NONE;
    repeat (8) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_status();
    t_events();
    t_rate();
    t_upload();
    conclude();
  end

  // The upload needs about 6k cycles; 40k cycles means a hang.
  initial begin
    #4000000;
    err_count++;
    conclude();
  end
endmodule : test_gsu_status_upload
